// >>> common/dtc_pkg.sv
// dtc_pkg: constants and types for the data transceiver controller
// assumes a single bus clock; no software registers
package dtc_pkg;
	localparam int NUM_BANKS = 2;
	localparam int NUM_LANES = 4;
	localparam int CLK_NS = 4;
	// wait cycles before the write-direction enable, past the address phase
	localparam logic [3:0] WR_HOLDOFF = 4'h1;
	// write wait used in place of WR_HOLDOFF after a read, before a write may drive the bus
	localparam logic [3:0] TURN_WAIT = 4'h2;
	// cycles of read-enable delay before the read window opens
	localparam logic [3:0] RD_DELAY = 4'h0;
	localparam logic [1:0] DIR_READ = 2'h1;
	localparam logic [1:0] DIR_WRITE = 2'h2;
	localparam logic [1:0] DIR_NONE = 2'h0;
	typedef enum logic [2:0] {
		DTC_IDLE = 3'b000,
		DTC_RD_SET = 3'b001,
		DTC_RD_ON = 3'b010,
		DTC_WR_SET = 3'b011,
		DTC_WR_ON = 3'b100,
		DTC_HOLD = 3'b101
	} dtc_state_t;
endpackage

// >>> hw/dtc_diag_latch.sv
// dtc_diag_latch: captures fetch-kind pins with the address strobe
// assumes addr_strobe_i is high for the address phase of each cycle
`timescale 1ns/1ps
module dtc_diag_latch (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic addr_strobe_i,
	input wire logic [1:0] fetch_kind_i,
	output logic [1:0] fetch_kind_o
);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fetch_kind_o <= 2'h0;
		end else if (addr_strobe_i) begin
			fetch_kind_o <= fetch_kind_i;
		end
	end
endmodule

// >>> hw/dtc_top.sv
// dtc_top: transceiver controls for a multiplexed address/data bus
// assumes strobes active high, synchronous to clk_i (the bus clock)
// Overview of operation
// - fetch-kind pins latched with the same strobe as the address.
// - memory side must release bus within half a clock after a read.
// - single bank: read enable is registered, needs read window, read-drive strobe and bank select.
// - several banks: read enable needs read-drive strobe and bank select.
// - write enable from write strobe, held until data is strobed in.
// - with wait states, write enable waits past the address phase.
// - write after read holds off write enable until read bus released.
// - partial writes enable only transceivers of written byte lanes.
// - direction pin changes only while outputs are disabled.
// - output enable window spans combined read and write strobes.
// - read output enable may be delayed by wait-state count.
// - read output enable drops on the edge read strobe negates.
// - direction set before output enable asserts.
// - direction held until edge after strobe ends, enable already off.
`timescale 1ns/1ps
module dtc_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic addr_strobe_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic read_drive_strobe_i,
	input wire logic [dtc_pkg::NUM_BANKS-1:0] bank_sel_i,
	input wire logic [dtc_pkg::NUM_LANES-1:0] byte_en_i,
	input wire logic [1:0] fetch_kind_i,
	output logic [dtc_pkg::NUM_BANKS-1:0] rd_oe_o,
	output logic [dtc_pkg::NUM_BANKS*dtc_pkg::NUM_LANES-1:0] wr_oe_o,
	output logic xcvr_oe_o,
	output logic xcvr_dir_wr_o,
	output logic [1:0] fetch_kind_o
);
	// ****************************************
	// state
	// ****************************************
	dtc_pkg::dtc_state_t state;
	dtc_pkg::dtc_state_t next_state;
	logic [3:0] wait_cnt;
	logic last_was_read;
	logic [dtc_pkg::NUM_BANKS-1:0] bank_q;
	logic [dtc_pkg::NUM_LANES-1:0] lanes_q;
	logic strobe_any;
	logic [3:0] wr_need;

	function automatic logic [dtc_pkg::NUM_LANES-1:0] lanes_of(
		input logic [dtc_pkg::NUM_LANES-1:0] be);
		lanes_of = be;
	endfunction

	assign strobe_any = rd_i | wr_i;
	// turnaround wait after a read covers the slow release
	assign wr_need = last_was_read ? dtc_pkg::TURN_WAIT : dtc_pkg::WR_HOLDOFF;

	always_comb begin
		next_state = state;
		case (state)
			dtc_pkg::DTC_IDLE: begin
				if (rd_i) begin
					next_state = dtc_pkg::DTC_RD_SET;
				end else if (wr_i) begin
					next_state = dtc_pkg::DTC_WR_SET;
				end
			end
			dtc_pkg::DTC_RD_SET: begin
				if (!rd_i) begin
					next_state = dtc_pkg::DTC_HOLD;
				end else if (wait_cnt >= dtc_pkg::RD_DELAY) begin
					next_state = dtc_pkg::DTC_RD_ON;
				end
			end
			dtc_pkg::DTC_RD_ON: begin
				if (!rd_i) begin
					next_state = dtc_pkg::DTC_HOLD;
				end
			end
			dtc_pkg::DTC_WR_SET: begin
				if (!wr_i) begin
					next_state = dtc_pkg::DTC_HOLD;
				end else if (wait_cnt >= wr_need) begin
					next_state = dtc_pkg::DTC_WR_ON;
				end
			end
			dtc_pkg::DTC_WR_ON: begin
				if (!wr_i) begin
					next_state = dtc_pkg::DTC_HOLD;
				end
			end
			dtc_pkg::DTC_HOLD: begin
				next_state = dtc_pkg::DTC_IDLE;
			end
			default: begin
				next_state = dtc_pkg::DTC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= dtc_pkg::DTC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_cnt <= 4'h0;
		end else if (state != next_state) begin
			wait_cnt <= 4'h0;
		end else if (wait_cnt != 4'hf) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			last_was_read <= 1'b0;
		end else if (state == dtc_pkg::DTC_RD_ON || state == dtc_pkg::DTC_RD_SET) begin
			last_was_read <= 1'b1;
		end else if (state == dtc_pkg::DTC_WR_ON) begin
			last_was_read <= 1'b0;
		end
	end

	// bank and lanes captured at cycle start, held through the cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bank_q <= '0;
			lanes_q <= '0;
		end else if (state == dtc_pkg::DTC_IDLE && strobe_any) begin
			bank_q <= bank_sel_i;
			lanes_q <= lanes_of(byte_en_i);
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// direction only moves in idle, when the enable is already low
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			xcvr_dir_wr_o <= 1'b0;
		end else if (state == dtc_pkg::DTC_IDLE && !xcvr_oe_o) begin
			if (wr_i && !rd_i) begin
				xcvr_dir_wr_o <= 1'b1;
			end else if (rd_i) begin
				xcvr_dir_wr_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			xcvr_oe_o <= 1'b0;
		end else begin
			xcvr_oe_o <= (next_state == dtc_pkg::DTC_RD_ON) ||
				(next_state == dtc_pkg::DTC_WR_ON);
		end
	end

	genvar b;
	generate
		for (b = 0; b < dtc_pkg::NUM_BANKS; b++) begin : g_bank
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					rd_oe_o[b] <= 1'b0;
				end else begin
					// read window also needs the processor read-drive strobe
					rd_oe_o[b] <= (next_state == dtc_pkg::DTC_RD_ON) &&
						read_drive_strobe_i && bank_q[b];
				end
			end
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					wr_oe_o[b*dtc_pkg::NUM_LANES +: dtc_pkg::NUM_LANES] <= '0;
				end else if (next_state == dtc_pkg::DTC_WR_ON && bank_q[b]) begin
					wr_oe_o[b*dtc_pkg::NUM_LANES +: dtc_pkg::NUM_LANES] <= lanes_q;
				end else begin
					wr_oe_o[b*dtc_pkg::NUM_LANES +: dtc_pkg::NUM_LANES] <= '0;
				end
			end
		end
	endgenerate

	dtc_diag_latch u_diag (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.addr_strobe_i(addr_strobe_i),
		.fetch_kind_i(fetch_kind_i),
		.fetch_kind_o(fetch_kind_o)
	);

	// ****************************************
	// checks
	// ****************************************
	AST_NO_CLASH: assert property (@(posedge clk_i) disable iff (rst_i)
		!(|(rd_oe_o & bank_q) && |wr_oe_o)) else $error("read and write enables together");
	AST_DIR_STABLE: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(xcvr_dir_wr_o) |-> !$past(xcvr_oe_o) && !xcvr_oe_o)
		else $error("direction moved while enabled");
	AST_RD_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == dtc_pkg::DTC_RD_ON && !rd_i) |=> !xcvr_oe_o && rd_oe_o == '0)
		else $error("read enable not dropped");
	AST_WR_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
		|wr_oe_o |-> xcvr_dir_wr_o) else $error("write enable without write direction");
	AST_RD_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
		|rd_oe_o |-> !xcvr_dir_wr_o) else $error("read enable without read direction");
	AST_WR_LATE: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == dtc_pkg::DTC_IDLE && wr_i && !rd_i) |=> wr_oe_o == '0)
		else $error("write enable during address phase");
	AST_WR_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == dtc_pkg::DTC_WR_ON && wr_i) |=> xcvr_oe_o)
		else $error("write enable dropped early");
	AST_LANES: assert property (@(posedge clk_i) disable iff (rst_i)
		|wr_oe_o |-> (wr_oe_o & ~{dtc_pkg::NUM_BANKS{lanes_q}}) == '0)
		else $error("unwritten lane enabled");
	AST_DIAG: assert property (@(posedge clk_i) disable iff (rst_i)
		addr_strobe_i |=> fetch_kind_o == $past(fetch_kind_i))
		else $error("fetch kind not latched");
	CV_READ: cover property (@(posedge clk_i) disable iff (rst_i) |rd_oe_o);
	CV_WRITE: cover property (@(posedge clk_i) disable iff (rst_i) |wr_oe_o);
	CV_TURN: cover property (@(posedge clk_i) disable iff (rst_i)
		last_was_read && state == dtc_pkg::DTC_WR_ON);
endmodule

// >>> test/dtc_cpu_model.sv
// dtc_cpu_model: processor side of the bus, strobes and bank selects
// assumes the bench calls its tasks, all changes just after clk_i rises
`timescale 1ns/1ps
module dtc_cpu_model (
	input wire logic clk_i,
	output logic addr_strobe_o,
	output logic rd_o,
	output logic wr_o,
	output logic read_drive_strobe_o,
	output logic [1:0] bank_sel_o,
	output logic [3:0] byte_en_o,
	output logic [1:0] fetch_kind_o
);
	// ****************
	// cycle tasks
	// ****************
	initial begin
		{addr_strobe_o, rd_o, wr_o, read_drive_strobe_o} = 4'h0;
		bank_sel_o = 2'h0;
		byte_en_o = 4'h0;
		fetch_kind_o = 2'h0;
	end
	task automatic start(input logic w, input logic [1:0] b, input logic [3:0] be,
		input logic [1:0] fk, input logic de);
		@(posedge clk_i);
		addr_strobe_o <= 1'b1;
		bank_sel_o <= b;
		byte_en_o <= be;
		fetch_kind_o <= fk;
		rd_o <= !w;
		wr_o <= w;
		read_drive_strobe_o <= de && !w;
		@(posedge clk_i);
		addr_strobe_o <= 1'b0;
		// pins move on after the address phase, latch must hold
		fetch_kind_o <= ~fk;
	endtask
	// next address may follow at once; write data outlives the strobe
	task automatic stop();
		@(posedge clk_i);
		rd_o <= 1'b0;
		wr_o <= 1'b0;
		read_drive_strobe_o <= 1'b0;
	endtask
endmodule

// >>> test/tb_top.sv
// tb_top: self-checking bench for the transceiver controller
// assumes dtc_top and dtc_cpu_model, 250 MHz bus clock
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic as, rd, wr, de;
	logic [1:0] bs, fk, fk_o;
	logic [3:0] be;
	logic [1:0] rd_oe;
	logic [7:0] wr_oe;
	logic oe, dir;
	int fails = 0;
	int num_checks = 0;
	dtc_cpu_model cpu (.clk_i(clk_i), .addr_strobe_o(as), .rd_o(rd), .wr_o(wr),
		.read_drive_strobe_o(de), .bank_sel_o(bs), .byte_en_o(be), .fetch_kind_o(fk));
	dtc_top uut (.clk_i(clk_i), .rst_i(rst_i), .addr_strobe_i(as), .rd_i(rd), .wr_i(wr),
		.read_drive_strobe_i(de), .bank_sel_i(bs), .byte_en_i(be), .fetch_kind_i(fk),
		.rd_oe_o(rd_oe), .wr_oe_o(wr_oe), .xcvr_oe_o(oe), .xcvr_dir_wr_o(dir),
		.fetch_kind_o(fk_o));
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	// ****************
	// checking
	// ****************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(negedge clk_i) begin
		if (!rst_i)
			chk({7'h0, |(rd_oe & {|wr_oe[7:4], |wr_oe[3:0]})}, 8'h0);
	end
	// one transfer: edges from start to enable, then the release
	task automatic xfer(input logic w, input logic [1:0] b, input logic [3:0] l,
		input logic d, input logic [1:0] f, input int n_exp);
		int n;
		cpu.start(w, b, l, f, d);
		// start edge has just been taken: direction set, enable still low
		#1;
		chk({6'h0, dir, oe}, {6'h0, w, 1'b0});
		for (n = 1; n < 20; n++) begin
			@(posedge clk_i);
			#1;
			if (oe === 1'b1)
				break;
		end
		if (n == 20) begin
			fails++;
			finish_test();
		end
		chk(8'(n), 8'(n_exp));
		chk({6'h0, rd_oe}, {6'h0, b & {2{d && !w}}});
		chk(wr_oe, w ? {{4{b[1]}} & l, {4{b[0]}} & l} : 8'h0);
		chk({6'h0, fk_o}, {6'h0, f});
		repeat (2) @(posedge clk_i);
		#1;
		chk({7'h0, oe}, 8'h1);
		cpu.stop();
		// first edge that sees the strobe low must already drop the enables
		@(posedge clk_i);
		#1;
		chk({5'h0, oe, |rd_oe, |wr_oe}, 8'h0);
		chk({7'h0, dir}, {7'h0, w});
		repeat (3) @(posedge clk_i);
	endtask
	task automatic t_read();
		xfer(1'b0, 2'h1, 4'hf, 1'b1, 2'h2, 1 + int'(dtc_pkg::RD_DELAY));
		$display("read done");
	endtask
	task automatic t_read_nodrive();
		xfer(1'b0, 2'h2, 4'hf, 1'b0, 2'h1, 1 + int'(dtc_pkg::RD_DELAY));
		$display("read without drive strobe done");
	endtask
	task automatic t_wr_after_rd();
		xfer(1'b1, 2'h2, 4'h5, 1'b0, 2'h3, 1 + int'(dtc_pkg::TURN_WAIT));
		$display("write after read done");
	endtask
	task automatic t_wr_after_wr();
		xfer(1'b1, 2'h1, 4'hf, 1'b0, 2'h0, 1 + int'(dtc_pkg::WR_HOLDOFF));
		$display("write after write done");
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_read();
		t_read_nodrive();
		t_wr_after_rd();
		t_wr_after_wr();
		finish_test();
	end
endmodule
